//--- src/bdm_data_memory.sv
// Purpose : banked data memory, pointers, accumulator, alu and flags
// Assumes : one request per two cycles from the core; same clock domain
// Notes   : peripheral registers live elsewhere and read as zero here
//
// How it works
// - special register area is the same in every bank.
// - unimplemented addresses below 40H read 00H, shared across banks.
// - storage 40H..FFH, bank select 0, 2 or 3 picks the bank.
// - any bit of storage, pointers, bank select, accumulator or flag bits 0..3 can be set or cleared singly.
// - address 00H uses pointer zero, 02H pointer one; no storage there.
// - indirect access that points at 00H or 02H reads 00H, writes nothing.
// - pointers are 8 bits; pointer zero bank 0, pointer one follows bank.
// - accumulator is location 05H and takes immediate operands.
// - alu does add, sub, decimal adjust, logic, rotates, inc, dec, tests.
// - every alu operation except move, rl, rr, set and clr updates flags as well as its result.
// - flag register at 0AH, upper two bits read zero.
// - software writes leave halted and watchdog flags alone.
// - bit 0 carry, or no borrow; rotate through carry updates it.
// - bit 1 nibble carry, or no nibble borrow in subtraction.
// - bit 2 set when result is zero.
// - bit 3 set when carry into msb differs from carry out.
// - bit 4 cleared at reset and watchdog kick, set by halt.
// - bit 5 cleared at reset, kick and halt; set on watchdog expiry.
// - flag register is never saved automatically on calls.
`timescale 1ns/1ps

module bdm_data_memory #(
  parameter int GP_DEPTH = bdm_pkg::GP_BYTES
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire bdm_pkg::bdm_req_t req,
  output bdm_pkg::bdm_rsp_t      rsp,
  input  wire logic             watchdog_kick_instruction,
  input  wire logic             halt_instruction,
  input  wire logic             watchdog_expiry,
  output logic [7:0]            flags
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    bdm_pkg::bdm_state_t st;
    bdm_pkg::bdm_req_t   cur;
    logic [7:0]          pointer_zero;
    logic [7:0]          pointer_one;
    logic [7:0]          bank_select;
    logic [7:0]          working_accumulator;
    logic                carry_flag;
    logic                half_nibble_flag;
    logic                zero_flag;
    logic                signed_wrap_flag;
    logic                halted_state_flag;
    logic                watchdog_expiry_flag;
    bdm_pkg::bdm_rsp_t   out;
  } bdm_regs_t;

  bdm_regs_t r;
  bdm_regs_t next_r;

  // flip-flop storage, three banks of general purpose bytes
  logic [7:0] mem [bdm_pkg::NUM_BANKS][GP_DEPTH];

  // ------------------------------------------------------------------
  // address resolution
  // ------------------------------------------------------------------
  logic [7:0] eff_addr;
  logic       indirect_self;
  logic       is_gp;
  logic [1:0] bank_idx;
  logic [7:0] gp_idx;
  logic [7:0] rd_val;
  logic [7:0] flag_byte;

  always_comb
  begin
    indirect_self = 1'b0;
    eff_addr      = r.cur.addr;
    bank_idx      = 2'd0;
    if (r.cur.addr == bdm_pkg::INDIRECT_PORT_ZERO)
    begin
      eff_addr = r.pointer_zero;
      bank_idx = 2'd0;
    end
    else if (r.cur.addr == bdm_pkg::INDIRECT_PORT_ONE)
    begin
      eff_addr = r.pointer_one;
      unique case (r.bank_select)
        8'h02:   bank_idx = 2'd1;
        8'h03:   bank_idx = 2'd2;
        default: bank_idx = 2'd0;
      endcase
    end
    else
    begin
      unique case (r.bank_select)
        8'h02:   bank_idx = 2'd1;
        8'h03:   bank_idx = 2'd2;
        default: bank_idx = 2'd0;
      endcase
    end
    if ((r.cur.addr == bdm_pkg::INDIRECT_PORT_ZERO ||
         r.cur.addr == bdm_pkg::INDIRECT_PORT_ONE) &&
        (eff_addr == bdm_pkg::INDIRECT_PORT_ZERO ||
         eff_addr == bdm_pkg::INDIRECT_PORT_ONE))
      indirect_self = 1'b1;
    is_gp  = (eff_addr >= bdm_pkg::GP_BASE);
    gp_idx = eff_addr - bdm_pkg::GP_BASE;
  end

  assign flag_byte = {2'b00,
                      r.watchdog_expiry_flag, r.halted_state_flag,
                      r.signed_wrap_flag, r.zero_flag,
                      r.half_nibble_flag, r.carry_flag};

  // special area ignores bank select entirely, so it mirrors everywhere
  always_comb
  begin
    rd_val = bdm_pkg::RESET_BYTE;
    if (indirect_self)
      rd_val = bdm_pkg::RESET_BYTE;
    else if (is_gp)
      rd_val = mem[bank_idx][gp_idx];
    else
      unique case (eff_addr)
        bdm_pkg::POINTER_ZERO_REG: rd_val = r.pointer_zero;
        bdm_pkg::POINTER_ONE_REG:  rd_val = r.pointer_one;
        bdm_pkg::BANK_SELECT_REG:  rd_val = r.bank_select;
        bdm_pkg::ACCUMULATOR_REG:  rd_val = r.working_accumulator;
        bdm_pkg::FLAG_REGISTER:    rd_val = flag_byte;
        default:                   rd_val = bdm_pkg::RESET_BYTE;
      endcase
  end

  // ------------------------------------------------------------------
  // alu
  // ------------------------------------------------------------------
  logic [7:0] opa;
  logic [7:0] opb;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;
  logic       c_out;
  logic       h_out;
  logic       v_out;
  logic       arith;
  logic       upd_c;
  logic       writes;
  logic [7:0] bmask;

  always_comb
  begin
    opa    = r.working_accumulator;
    opb    = r.cur.use_imm ? r.cur.imm : rd_val;
    sum    = 9'h000;
    nib    = 5'h00;
    res    = opb;
    c_out  = r.carry_flag;
    h_out  = r.half_nibble_flag;
    v_out  = r.signed_wrap_flag;
    arith  = 1'b0;
    upd_c  = 1'b0;
    writes = 1'b1;
    bmask  = 8'h01 << r.cur.bit_sel;
    unique case (r.cur.op)
      bdm_pkg::BDM_OP_ADD, bdm_pkg::BDM_OP_ADC:
      begin
        arith = 1'b1;
        sum = {1'b0, opa} + {1'b0, opb} +
              {8'h00, (r.cur.op == bdm_pkg::BDM_OP_ADC) & r.carry_flag};
        nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} +
              {4'h0, (r.cur.op == bdm_pkg::BDM_OP_ADC) & r.carry_flag};
      end
      bdm_pkg::BDM_OP_SUB, bdm_pkg::BDM_OP_SBC:
      begin
        // a - b computed as a + ~b + cin, carry out is "no borrow"
        arith = 1'b1;
        sum = {1'b0, opa} + {1'b0, ~opb} +
              {8'h00, (r.cur.op == bdm_pkg::BDM_OP_SUB) | r.carry_flag};
        nib = {1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} +
              {4'h0, (r.cur.op == bdm_pkg::BDM_OP_SUB) | r.carry_flag};
      end
      bdm_pkg::BDM_OP_DAA:
      begin
        sum = {1'b0, opa};
        if (opa[3:0] > 4'h9 || r.half_nibble_flag)
          sum = sum + 9'h006;
        if (sum[7:4] > 4'h9 || r.carry_flag || sum[8])
          sum = sum + 9'h060;
        res   = sum[7:0];
        upd_c = 1'b1;
        c_out = sum[8] | r.carry_flag;
      end
      bdm_pkg::BDM_OP_AND:  res = opa & opb;
      bdm_pkg::BDM_OP_OR:   res = opa | opb;
      bdm_pkg::BDM_OP_XOR:  res = opa ^ opb;
      bdm_pkg::BDM_OP_CPL:  res = ~opb;
      bdm_pkg::BDM_OP_RL:   res = {opb[6:0], opb[7]};
      bdm_pkg::BDM_OP_RR:   res = {opb[0], opb[7:1]};
      bdm_pkg::BDM_OP_RLC:
      begin
        res   = {opb[6:0], r.carry_flag};
        upd_c = 1'b1;
        c_out = opb[7];
      end
      bdm_pkg::BDM_OP_RRC:
      begin
        res   = {r.carry_flag, opb[7:1]};
        upd_c = 1'b1;
        c_out = opb[0];
      end
      bdm_pkg::BDM_OP_INC:  res = opb + 8'h01;
      bdm_pkg::BDM_OP_DEC:  res = opb - 8'h01;
      bdm_pkg::BDM_OP_SET:  res = opb | bmask;
      bdm_pkg::BDM_OP_CLR:  res = opb & ~bmask;
      bdm_pkg::BDM_OP_MOVE: res = opb;
      default:              writes = 1'b0;
    endcase
    if (arith)
    begin
      res   = sum[7:0];
      upd_c = 1'b1;
      c_out = sum[8];
      h_out = nib[4];
      v_out = sum[8] ^ (opa[7] ^ opb[7] ^ sum[7] ^
              (r.cur.op == bdm_pkg::BDM_OP_SUB ||
               r.cur.op == bdm_pkg::BDM_OP_SBC));
    end
  end

  logic affects_z;
  assign affects_z = !(r.cur.op == bdm_pkg::BDM_OP_MOVE ||
                       r.cur.op == bdm_pkg::BDM_OP_SET  ||
                       r.cur.op == bdm_pkg::BDM_OP_CLR  ||
                       r.cur.op == bdm_pkg::BDM_OP_RL   ||
                       r.cur.op == bdm_pkg::BDM_OP_RR   ||
                       r.cur.op == bdm_pkg::BDM_OP_RLC  ||
                       r.cur.op == bdm_pkg::BDM_OP_RRC  ||
                       r.cur.op == bdm_pkg::BDM_OP_NONE);

  // ------------------------------------------------------------------
  // sequencing and register update
  // ------------------------------------------------------------------
  logic       wr_en;
  logic [7:0] wr_data;

  always_comb
  begin
    next_r          = r;
    next_r.out.done = 1'b0;
    wr_en           = 1'b0;
    wr_data         = res;
    unique case (r.st)
      bdm_pkg::BDM_ST_IDLE:
      begin
        if (req.valid)
        begin
          next_r.cur = req;
          next_r.st  = bdm_pkg::BDM_ST_EXEC;
        end
      end
      bdm_pkg::BDM_ST_EXEC:
      begin
        next_r.st             = bdm_pkg::BDM_ST_IDLE;
        next_r.out.done       = 1'b1;
        next_r.out.rdata      = rd_val;
        next_r.out.result     = res;
        next_r.out.is_zero    = (res == 8'h00);     // skip-test decision
        if (r.cur.op != bdm_pkg::BDM_OP_NONE)
        begin
          if (r.cur.to_acc)
            next_r.working_accumulator = res;
          else if (writes && !indirect_self)
            wr_en = 1'b1;
        end
        // memory-mapped special registers
        if (wr_en && !is_gp)
          unique case (eff_addr)
            bdm_pkg::POINTER_ZERO_REG: next_r.pointer_zero = res;
            bdm_pkg::POINTER_ONE_REG:  next_r.pointer_one = res;
            bdm_pkg::BANK_SELECT_REG:  next_r.bank_select = res;
            bdm_pkg::ACCUMULATOR_REG:  next_r.working_accumulator = res;
            bdm_pkg::FLAG_REGISTER:
            begin
              next_r.carry_flag       = res[bdm_pkg::FLAG_CARRY];
              next_r.half_nibble_flag = res[bdm_pkg::FLAG_HALF];
              next_r.zero_flag        = res[bdm_pkg::FLAG_ZERO];
              next_r.signed_wrap_flag = res[bdm_pkg::FLAG_WRAP];
            end
            default: ;
          endcase
        // alu flag update wins over a plain store into the flag byte
        if (r.cur.op != bdm_pkg::BDM_OP_MOVE &&
            r.cur.op != bdm_pkg::BDM_OP_NONE)
        begin
          if (upd_c)
            next_r.carry_flag = c_out;
          if (affects_z)
            next_r.zero_flag = (res == 8'h00);
          if (arith)
          begin
            next_r.half_nibble_flag = h_out;
            next_r.signed_wrap_flag = v_out;
          end
        end
      end
      default: next_r.st = bdm_pkg::BDM_ST_IDLE;
    endcase
    if (watchdog_kick_instruction)
    begin
      next_r.halted_state_flag    = 1'b0;
      next_r.watchdog_expiry_flag = 1'b0;
    end
    if (halt_instruction)
    begin
      next_r.halted_state_flag    = 1'b1;
      next_r.watchdog_expiry_flag = 1'b0;
    end
    if (watchdog_expiry)
      next_r.watchdog_expiry_flag = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      r    <= '0;
      r.st <= bdm_pkg::BDM_ST_IDLE;
    end
    else
      r <= next_r;
  end

  // storage has no reset; contents are undefined after power-up
  always_ff @(posedge sys_clk)
  begin
    if (wr_en && is_gp)
      mem[bank_idx][gp_idx] <= wr_data;
  end

  assign rsp   = r.out;
  assign flags = flag_byte;

endmodule : bdm_data_memory

//--- src/bdm_pkg.sv
// Purpose : shared constants and carriers for the banked data memory block
// Assumes : 8-bit data path, 8-bit data addresses, banks 0, 2 and 3
// Notes   : alu operation codes are local to this block's core port
package bdm_pkg;

  // ------------------------------------------------------------------
  // address map
  // ------------------------------------------------------------------
  localparam logic [7:0] INDIRECT_PORT_ZERO = 8'h00;
  localparam logic [7:0] POINTER_ZERO_REG   = 8'h01;
  localparam logic [7:0] INDIRECT_PORT_ONE  = 8'h02;
  localparam logic [7:0] POINTER_ONE_REG    = 8'h03;
  localparam logic [7:0] BANK_SELECT_REG    = 8'h04;
  localparam logic [7:0] ACCUMULATOR_REG    = 8'h05;
  localparam logic [7:0] FLAG_REGISTER      = 8'h0A;
  localparam logic [7:0] GP_BASE            = 8'h40;
  localparam int         GP_BYTES           = 192;
  localparam int         NUM_BANKS          = 3;

  // ------------------------------------------------------------------
  // flag register fields
  // ------------------------------------------------------------------
  localparam int FLAG_CARRY   = 0;
  localparam int FLAG_HALF    = 1;
  localparam int FLAG_ZERO    = 2;
  localparam int FLAG_WRAP    = 3;
  localparam int FLAG_HALTED  = 4;
  localparam int FLAG_WDOG    = 5;
  localparam logic [7:0] FLAG_WRITE_MASK = 8'h0F;
  localparam logic [7:0] RESET_BYTE      = 8'h00;

  // ------------------------------------------------------------------
  // core operation codes
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    BDM_OP_NONE = 5'h00, BDM_OP_MOVE = 5'h01, BDM_OP_ADD  = 5'h02,
    BDM_OP_ADC  = 5'h03, BDM_OP_SUB  = 5'h04, BDM_OP_SBC  = 5'h05,
    BDM_OP_DAA  = 5'h06, BDM_OP_AND  = 5'h07, BDM_OP_OR   = 5'h08,
    BDM_OP_XOR  = 5'h09, BDM_OP_CPL  = 5'h0A, BDM_OP_RL   = 5'h0B,
    BDM_OP_RR   = 5'h0C, BDM_OP_RLC  = 5'h0D, BDM_OP_RRC  = 5'h0E,
    BDM_OP_INC  = 5'h0F, BDM_OP_DEC  = 5'h10, BDM_OP_SET  = 5'h11,
    BDM_OP_CLR  = 5'h12
  } bdm_op_t;

  // one request from the instruction logic
  typedef struct packed {
    logic       valid;
    bdm_op_t    op;
    logic [7:0] addr;
    logic       use_imm;
    logic [7:0] imm;
    logic       to_acc;
    logic [2:0] bit_sel;
  } bdm_req_t;

  // one answer to the instruction logic
  typedef struct packed {
    logic       done;
    logic [7:0] rdata;
    logic [7:0] result;
    logic       is_zero;
  } bdm_rsp_t;

  typedef enum logic [1:0] {
    BDM_ST_IDLE = 2'b01,
    BDM_ST_EXEC = 2'b10
  } bdm_state_t;

endpackage : bdm_pkg

//--- tb/bdm_core_model.sv
// Purpose : instruction-logic stand-in that issues one request at a time
// Assumes : caller builds the request; gap adds idle cycles before it
// Notes   : valid drops at the taking edge, answer awaited at most 8 cycles
`timescale 1ns/1ps

module bdm_core_model (
  input  wire logic              sys_clk,
  output bdm_pkg::bdm_req_t      req,
  input  wire bdm_pkg::bdm_rsp_t rsp
);
  int gap = 0;

  initial req = '0;

  // memory to memory traffic is always split through the accumulator and
  // never goes from one indirect port to the other
  task automatic xfer(input bdm_pkg::bdm_req_t r, output logic got);
    int n;
    got = 1'b0;
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    req <= r;
    @(posedge sys_clk);
    req.valid <= 1'b0;
    for (n = 0; n < 8 && !got; n++)
    begin
      @(negedge sys_clk);
      got = rsp.done;
    end
  endtask : xfer
endmodule : bdm_core_model

//--- tb/bdm_data_memory_properties.sv
// Purpose : port-level timing and flag checks for the data memory
// Assumes : one clock, synchronous active-low reset
// Notes   : busy mirrors the one-request-per-two-cycles pipeline
`timescale 1ns/1ps

module bdm_data_memory_properties #(
  parameter int GP_DEPTH = bdm_pkg::GP_BYTES
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire bdm_pkg::bdm_req_t req,
  input wire bdm_pkg::bdm_rsp_t rsp,
  input wire logic              watchdog_kick_instruction,
  input wire logic              halt_instruction,
  input wire logic              watchdog_expiry,
  input wire logic [7:0]        flags
);
  // ------------------------------------------------------------------
  // helpers and properties
  // ------------------------------------------------------------------
  logic              busy;
  logic [1:0]        took;
  bdm_pkg::bdm_req_t r1;
  bdm_pkg::bdm_req_t r2;
  wire take = req.valid && !busy;
  wire pls  = watchdog_kick_instruction || halt_instruction;
  wire zop  = r2.op inside {[bdm_pkg::BDM_OP_ADD:bdm_pkg::BDM_OP_CPL],
                            bdm_pkg::BDM_OP_INC, bdm_pkg::BDM_OP_DEC};

  always_ff @(posedge sys_clk)
  begin
    busy <= rst_n && take;
    took <= rst_n ? {took[0], take} : 2'b00;
    r1   <= req;
    r2   <= r1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_take;
    take;
  endsequence
  sequence s_answer;
    ##2 rsp.done;
  endsequence
  property p_latency;
    s_take |-> s_answer;
  endproperty

  AST_LATENCY: assert property (p_latency)
    else $error("answer not two cycles after request");
  AST_DONE_CAUSE: assert property (rsp.done |-> took[1])
    else $error("answer without request");
  AST_HOLD: assert property (!rsp.done |-> $stable(rsp.result)
    && $stable(rsp.rdata)) else $error("answer changed between pulses");
  AST_UPPER_ZERO: assert property (flags[7:6] == 2'b00)
    else $error("upper flag bits set");
  AST_SW_KEEPS: assert property (!$past(pls || watchdog_expiry)
    |-> $stable(flags[5:4])) else $error("halt or watchdog flag moved");
  AST_HALT_SET: assert property (halt_instruction |=> flags[4])
    else $error("halt did not set halted flag");
  AST_KICK_CLR: assert property (watchdog_kick_instruction
    && !halt_instruction |=> !flags[4]) else $error("kick kept halted");
  AST_EXPIRY_SET: assert property (watchdog_expiry |=> flags[5])
    else $error("expiry flag not set");
  AST_EXPIRY_CLR: assert property (pls && !watchdog_expiry
    |=> !flags[5]) else $error("expiry flag not cleared");
  AST_ZERO_FLAG: assert property (rsp.done && zop |->
    flags[2] == (rsp.result == 8'h00) && rsp.is_zero == flags[2])
    else $error("zero flag wrong");
  AST_RESERVED_ZERO: assert property (rsp.done && !r2.use_imm
    && r2.addr inside {[8'h0B:8'h3F]} |-> rsp.rdata == 8'h00)
    else $error("unimplemented location not zero");
endmodule : bdm_data_memory_properties

bind bdm_data_memory bdm_data_memory_properties #(.GP_DEPTH(GP_DEPTH))
  i_props (
    .sys_clk                   (sys_clk),
    .rst_n                     (rst_n),
    .req                       (req),
    .rsp                       (rsp),
    .watchdog_kick_instruction (watchdog_kick_instruction),
    .halt_instruction          (halt_instruction),
    .watchdog_expiry           (watchdog_expiry),
    .flags                     (flags)
  );

//--- tb/tb_banked_data_memory_flags.sv
// Purpose : self-checking bench for banked memory, pointers, alu and flags
// Assumes : memory write is an immediate load of the accumulator then a move
// Notes   : single-operand alu cases use the same value in acc and operand
`timescale 1ns/1ps

module tb_banked_data_memory_flags;
  // ------------------------------------------------------------------
  // harness
  // ------------------------------------------------------------------
  typedef struct packed {
    bdm_pkg::bdm_op_t op;
    logic [7:0]       a;
    logic [7:0]       b;
    logic [7:0]       res;
    logic [3:0]       fin;
    logic [3:0]       fout;
  } bdm_case_t;

  logic              sys_clk;
  logic              rst_n;
  logic [2:0]        ev;
  logic              got;
  logic [7:0]        flags;
  bdm_pkg::bdm_req_t req;
  bdm_pkg::bdm_rsp_t rsp;
  int                miscompares = 0;
  int                comparisons = 0;
  bdm_case_t cases [16] = '{
    '{bdm_pkg::BDM_OP_ADD, 8'h0F, 8'h01, 8'h10, 4'h0, 4'h2},
    '{bdm_pkg::BDM_OP_ADD, 8'h80, 8'h80, 8'h00, 4'h0, 4'hD},
    '{bdm_pkg::BDM_OP_ADC, 8'h01, 8'h01, 8'h03, 4'h1, 4'h0},
    '{bdm_pkg::BDM_OP_SUB, 8'h05, 8'h05, 8'h00, 4'h0, 4'h7},
    '{bdm_pkg::BDM_OP_SBC, 8'h10, 8'h01, 8'h0F, 4'h1, 4'h1},
    '{bdm_pkg::BDM_OP_DAA, 8'h0A, 8'h0A, 8'h10, 4'h0, 4'h0},
    '{bdm_pkg::BDM_OP_AND, 8'hF0, 8'h0F, 8'h00, 4'hB, 4'hF},
    '{bdm_pkg::BDM_OP_OR,  8'hF0, 8'h0F, 8'hFF, 4'h4, 4'h0},
    '{bdm_pkg::BDM_OP_XOR, 8'hAA, 8'hAA, 8'h00, 4'h0, 4'h4},
    '{bdm_pkg::BDM_OP_CPL, 8'hFF, 8'hFF, 8'h00, 4'h0, 4'h4},
    '{bdm_pkg::BDM_OP_RL,  8'h81, 8'h81, 8'h03, 4'h0, 4'h0},
    '{bdm_pkg::BDM_OP_RR,  8'h81, 8'h81, 8'hC0, 4'h0, 4'h0},
    '{bdm_pkg::BDM_OP_RLC, 8'h80, 8'h80, 8'h00, 4'h0, 4'h1},
    '{bdm_pkg::BDM_OP_RRC, 8'h01, 8'h01, 8'h80, 4'h1, 4'h1},
    '{bdm_pkg::BDM_OP_INC, 8'hFF, 8'hFF, 8'h00, 4'h0, 4'h4},
    '{bdm_pkg::BDM_OP_DEC, 8'h01, 8'h01, 8'h00, 4'h0, 4'h4}};

  bdm_data_memory i_dut (
    .sys_clk                   (sys_clk),
    .rst_n                     (rst_n),
    .req                       (req),
    .rsp                       (rsp),
    .watchdog_kick_instruction (ev[0]),
    .halt_instruction          (ev[1]),
    .watchdog_expiry           (ev[2]),
    .flags                     (flags)
  );

  bdm_core_model i_core (
    .sys_clk (sys_clk),
    .req     (req),
    .rsp     (rsp)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic run(input bdm_pkg::bdm_op_t op, input logic [7:0] a,
                     input logic ui, input logic [7:0] im,
                     input logic ta, input logic [2:0] b);
    i_core.xfer({1'b1, op, a, ui, im, ta, b}, got);
    chk("done", {7'h00, got}, 8'h01);
  endtask : run

  // the immediate is loaded first so either move reading stores it
  task automatic wr(input logic [7:0] a, d);
    run(bdm_pkg::BDM_OP_MOVE, a, 1'b1, d, 1'b1, 3'h0);
    run(bdm_pkg::BDM_OP_MOVE, a, 1'b1, d, 1'b0, 3'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, exp);
    run(bdm_pkg::BDM_OP_MOVE, a, 1'b0, 8'h00, 1'b1, 3'h0);
    chk("rdata", rsp.rdata, exp);
  endtask : rd

  task automatic pls(input logic [2:0] e, input logic [7:0] exp);
    @(posedge sys_clk);
    ev <= e;
    @(posedge sys_clk);
    ev <= 3'h0;
    @(negedge sys_clk);
    chk("flags", flags, exp);
  endtask : pls

  function automatic logic [7:0] bank(input int i);
    return (i == 0) ? 8'h00 : 8'(i + 1);
  endfunction : bank

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    ev    = 3'h0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk("flags", flags, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(bdm_pkg::BANK_SELECT_REG, bank(i));
      wr(8'h40, 8'h10 + bank(i));
      wr(8'hFF, 8'hA0 + bank(i));
      wr(8'h3F, 8'h5A);
    end
    wr(bdm_pkg::POINTER_ZERO_REG, 8'h40);
    wr(bdm_pkg::POINTER_ONE_REG, 8'h40);
    for (int i = 0; i < 3; i++)
    begin
      wr(bdm_pkg::BANK_SELECT_REG, bank(i));
      rd(8'h40, 8'h10 + bank(i));
      rd(8'hFF, 8'hA0 + bank(i));
      rd(8'h3F, 8'h00);
      rd(bdm_pkg::POINTER_ONE_REG, 8'h40);
      rd(bdm_pkg::INDIRECT_PORT_ONE, 8'h10 + bank(i));
      rd(bdm_pkg::INDIRECT_PORT_ZERO, 8'h10);
    end
    wr(bdm_pkg::INDIRECT_PORT_ZERO, 8'h55);
    wr(bdm_pkg::BANK_SELECT_REG, 8'h00);
    rd(8'h40, 8'h55);
    run(bdm_pkg::BDM_OP_SET, 8'h40, 1'b0, 8'h00, 1'b0, 3'h7);
    run(bdm_pkg::BDM_OP_CLR, 8'h40, 1'b0, 8'h00, 1'b0, 3'h2);
    rd(8'h40, 8'hD1);
    wr(bdm_pkg::BANK_SELECT_REG, 8'h01);
    rd(8'h40, 8'hD1);
    wr(bdm_pkg::POINTER_ZERO_REG, bdm_pkg::INDIRECT_PORT_ONE);
    wr(bdm_pkg::POINTER_ONE_REG, bdm_pkg::INDIRECT_PORT_ZERO);
    rd(bdm_pkg::INDIRECT_PORT_ZERO, 8'h00);
    rd(bdm_pkg::INDIRECT_PORT_ONE, 8'h00);
    wr(bdm_pkg::INDIRECT_PORT_ZERO, 8'h66);
    wr(bdm_pkg::INDIRECT_PORT_ONE, 8'h66);
    rd(bdm_pkg::POINTER_ZERO_REG, 8'h02);
    rd(bdm_pkg::POINTER_ONE_REG, 8'h00);
    i_core.gap = 2;
    foreach (cases[i])
    begin
      wr(bdm_pkg::FLAG_REGISTER, {4'h0, cases[i].fin});
      run(bdm_pkg::BDM_OP_MOVE, 8'h40, 1'b1, cases[i].a, 1'b1, 3'h0);
      run(cases[i].op, 8'h40, 1'b1, cases[i].b, 1'b1, 3'h0);
      chk("result", rsp.result, cases[i].res);
      chk("is_zero", {7'h00, rsp.is_zero},
          {7'h00, cases[i].res == 8'h00});
      chk("flags", flags, {4'h0, cases[i].fout});
    end
    i_core.gap = 0;
    run(bdm_pkg::BDM_OP_NONE, bdm_pkg::ACCUMULATOR_REG, 1'b1, 8'hEE, 1'b1,
        3'h0);
    rd(bdm_pkg::ACCUMULATOR_REG, 8'h00);
    wr(bdm_pkg::FLAG_REGISTER, 8'hFF);
    chk("flags", flags, 8'h0F);
    pls(3'b010, 8'h1F);
    pls(3'b100, 8'h3F);
    wr(bdm_pkg::FLAG_REGISTER, 8'h00);
    rd(bdm_pkg::FLAG_REGISTER, 8'h30);
    pls(3'b001, 8'h00);
    pls(3'b110, 8'h30);
    pls(3'b011, 8'h10);
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
endmodule : tb_banked_data_memory_flags
